// [src/pcg_defines.svh]
/*
  register offsets, field positions, masks and reset values of the peripheral clock gating block.
  assumes a 32-bit apb slave port with byte addresses in the low 12 bits.
*/
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

`define PCG_RUN_GATE_OFS 12'h104
`define PCG_SLEEP_GATE_OFS 12'h114
`define PCG_DEEP_GATE_OFS 12'h124
`define PCG_PWR_CTRL_OFS 12'h000
`define PCG_EFF_GATE_OFS 12'h004
`define PCG_FAULT_OFS 12'h008

`define PCG_TIMER_LSB 16
`define PCG_TIMER_MSB 19
`define PCG_QEI_BIT 8
`define PCG_SSI_BIT 4
`define PCG_UART_BIT 0

`define PCG_GATE_RW_MASK 32'h000f0111
`define PCG_GATE_RESET 32'h00000000
`define PCG_ACG_BIT 0
`define PCG_PSTATE_LSB 24
`define PCG_CTRL_RESET 1'h0

`endif

// [src/pcg_pkg.sv]
/*
  types of the peripheral clock gating block.
  assumes pcg_defines.svh supplies the numeric constants.
*/
package pcg_pkg;

  typedef struct packed {
    logic gp_timer_three_gate;
    logic gp_timer_two_gate;
    logic gp_timer_one_gate;
    logic gp_timer_zero_gate;
    logic quadrature_encoder_gate;
    logic sync_serial_port_gate;
    logic async_serial_port_gate;
  } pcg_gate_t;

  typedef enum logic [1:0] {
    PCG_RUN,
    PCG_SLEEP,
    PCG_DEEP
  } pcg_pstate_t;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } pcg_apb_req_t;

endpackage : pcg_pkg

// [src/pcg_unit_gate.sv]
/*
  clock enable and bus guard for one gated unit.
  assumes the upstream bus follows apb phases and the unit sits behind dn_psel.
*/
module pcg_unit_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic gate_en,
  input wire logic up_psel,
  input wire logic up_penable,
  input wire logic dn_pready,
  input wire logic dn_pslverr,
  output logic clk_en,
  output logic blocked,
  output logic dn_psel,
  output logic up_pready,
  output logic up_pslverr,
  output logic fault_pulse
);

  logic clk_en_r;
  logic blocked_r;
  wire setup_w = up_psel & ~up_penable;
  wire access_w = up_psel & up_penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_r <= 1'b0;
    end else begin
      clk_en_r <= gate_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blocked_r <= 1'b0;
    end else if (setup_w) begin
      blocked_r <= ~clk_en_r;
    end
  end

  assign clk_en = clk_en_r;
  assign blocked = setup_w ? ~clk_en_r : blocked_r;
  assign dn_psel = up_psel & ~blocked;
  assign up_pready = blocked ? 1'b1 : dn_pready;
  assign up_pslverr = blocked ? access_w : dn_pslverr;
  assign fault_pulse = access_w & blocked;

endmodule : pcg_unit_gate

// [src/pcg_clock_gate_ctrl.sv]
/*
  peripheral clock gating control: run, sleep and deep-sleep gating registers on apb,
  power-state selection, per-unit clock enables and a bus guard for the gated units.
  assumes a single pclk, power state levels synchronous to pclk and one-hot unit selects.
*/
`include "pcg_defines.svh"

module pcg_clock_gate_ctrl
  import pcg_pkg::*;
#(
  parameter int NUM_UNITS = 7,
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  output logic [NUM_UNITS-1:0] unit_clk_en,
  input wire logic [NUM_UNITS-1:0] per_psel,
  input wire logic per_penable,
  output logic [31:0] per_prdata,
  output logic per_pready,
  output logic per_pslverr,
  output logic [NUM_UNITS-1:0] unit_psel,
  input wire logic [NUM_UNITS-1:0] unit_pready,
  input wire logic [NUM_UNITS-1:0] unit_pslverr,
  input wire logic [NUM_UNITS-1:0][31:0] unit_prdata
);

  // register word to unit enable vector
  function automatic pcg_gate_t word_to_gate(input logic [31:0] w);
    pcg_gate_t g;
    g = '0;
    g.gp_timer_three_gate = w[`PCG_TIMER_MSB];
    g.gp_timer_two_gate = w[`PCG_TIMER_LSB + 2];
    g.gp_timer_one_gate = w[`PCG_TIMER_LSB + 1];
    g.gp_timer_zero_gate = w[`PCG_TIMER_LSB];
    g.quadrature_encoder_gate = w[`PCG_QEI_BIT];
    g.sync_serial_port_gate = w[`PCG_SSI_BIT];
    g.async_serial_port_gate = w[`PCG_UART_BIT];
    return g;
  endfunction : word_to_gate

  // unit enable vector to register word
  function automatic logic [31:0] gate_to_word(input pcg_gate_t g);
    logic [31:0] w;
    w = 32'h00000000;
    w[`PCG_TIMER_MSB] = g.gp_timer_three_gate;
    w[`PCG_TIMER_LSB + 2] = g.gp_timer_two_gate;
    w[`PCG_TIMER_LSB + 1] = g.gp_timer_one_gate;
    w[`PCG_TIMER_LSB] = g.gp_timer_zero_gate;
    w[`PCG_QEI_BIT] = g.quadrature_encoder_gate;
    w[`PCG_SSI_BIT] = g.sync_serial_port_gate;
    w[`PCG_UART_BIT] = g.async_serial_port_gate;
    return w;
  endfunction : gate_to_word

  // full-word gate write with reserved bits held at zero
  function automatic logic [31:0] gate_write(input logic [31:0] wdata);
    return wdata & `PCG_GATE_RW_MASK;
  endfunction : gate_write

  // apb request carrier
  pcg_apb_req_t req;
  assign req.addr = paddr[11:0];
  assign req.write = pwrite;
  assign req.wdata = pwdata;

  // phase decode
  wire setup_w = psel & ~penable;
  wire access_w = psel & penable;
  wire wr_en_w = access_w & req.write;

  // address decode
  // gating, control, status and fault register offsets
  wire hit_run_w = (req.addr == `PCG_RUN_GATE_OFS);
  wire hit_sleep_w = (req.addr == `PCG_SLEEP_GATE_OFS);
  wire hit_deep_w = (req.addr == `PCG_DEEP_GATE_OFS);
  wire hit_ctrl_w = (req.addr == `PCG_PWR_CTRL_OFS);
  wire hit_eff_w = (req.addr == `PCG_EFF_GATE_OFS);
  wire hit_fault_w = (req.addr == `PCG_FAULT_OFS);
  wire hit_any_w = hit_run_w | hit_sleep_w | hit_deep_w | hit_ctrl_w | hit_eff_w | hit_fault_w;

  // register state
  logic [31:0] run_state_periph_clock_gate_r;
  logic [31:0] sleep_state_periph_clock_gate_r;
  logic [31:0] deep_sleep_periph_clock_gate_r;
  logic auto_clock_gating_select_r;
  pcg_gate_t fault_r;
  pcg_gate_t fault_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  pcg_pstate_t pstate_r;
  pcg_pstate_t pstate_nxt;

  // one gating register per power state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_state_periph_clock_gate_r <= `PCG_GATE_RESET;
    end else if (wr_en_w && hit_run_w) begin
      run_state_periph_clock_gate_r <= gate_write(req.wdata);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_state_periph_clock_gate_r <= `PCG_GATE_RESET;
    end else if (wr_en_w && hit_sleep_w) begin
      sleep_state_periph_clock_gate_r <= gate_write(req.wdata);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_sleep_periph_clock_gate_r <= `PCG_GATE_RESET;
    end else if (wr_en_w && hit_deep_w) begin
      deep_sleep_periph_clock_gate_r <= gate_write(req.wdata);
    end
  end

  // automatic gating select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_clock_gating_select_r <= `PCG_CTRL_RESET;
    end else if (wr_en_w && hit_ctrl_w) begin
      auto_clock_gating_select_r <= req.wdata[`PCG_ACG_BIT];
    end
  end

  // power state tracking
  always_comb begin
    pstate_nxt = pstate_r;
    case (pstate_r)
      PCG_RUN: begin
        if (deep_sleep_mode) begin
          pstate_nxt = PCG_DEEP;
        end else if (sleep_mode) begin
          pstate_nxt = PCG_SLEEP;
        end
      end
      PCG_SLEEP: begin
        if (deep_sleep_mode) begin
          pstate_nxt = PCG_DEEP;
        end else if (!sleep_mode) begin
          pstate_nxt = PCG_RUN;
        end
      end
      PCG_DEEP: begin
        if (!deep_sleep_mode) begin
          pstate_nxt = sleep_mode ? PCG_SLEEP : PCG_RUN;
        end
      end
      default: begin
        pstate_nxt = PCG_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate_r <= PCG_RUN;
    end else begin
      pstate_r <= pstate_nxt;
    end
  end

  // effective gate selection
  logic [31:0] eff_word;
  always_comb begin
    eff_word = run_state_periph_clock_gate_r;
    case (pstate_r)
      PCG_RUN: begin
        eff_word = run_state_periph_clock_gate_r;
      end
      PCG_SLEEP: begin
        eff_word = auto_clock_gating_select_r ? sleep_state_periph_clock_gate_r
                                              : run_state_periph_clock_gate_r;
      end
      PCG_DEEP: begin
        eff_word = auto_clock_gating_select_r ? deep_sleep_periph_clock_gate_r
                                              : run_state_periph_clock_gate_r;
      end
      default: begin
        eff_word = run_state_periph_clock_gate_r;
      end
    endcase
  end

  wire pcg_gate_t eff_gate = word_to_gate(eff_word);
  wire [NUM_UNITS-1:0] eff_vec = eff_gate;

  // per-unit gates
  logic [NUM_UNITS-1:0] unit_clk_en_w;
  logic [NUM_UNITS-1:0] blocked_w;
  logic [NUM_UNITS-1:0] up_pready_w;
  logic [NUM_UNITS-1:0] up_pslverr_w;
  logic [NUM_UNITS-1:0] fault_pulse_w;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
      pcg_unit_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .gate_en(eff_vec[gi]),
        .up_psel(per_psel[gi]),
        .up_penable(per_penable),
        .dn_pready(unit_pready[gi]),
        .dn_pslverr(unit_pslverr[gi]),
        .clk_en(unit_clk_en_w[gi]),
        .blocked(blocked_w[gi]),
        .dn_psel(unit_psel[gi]),
        .up_pready(up_pready_w[gi]),
        .up_pslverr(up_pslverr_w[gi]),
        .fault_pulse(fault_pulse_w[gi])
      );
    end
  endgenerate

  assign unit_clk_en = unit_clk_en_w;

  // peripheral answer merge
  always_comb begin
    per_pready = 1'b0;
    per_pslverr = 1'b0;
    per_prdata = 32'h00000000;
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (per_psel[i]) begin
        per_pready = per_pready | up_pready_w[i];
        per_pslverr = per_pslverr | up_pslverr_w[i];
        if (!blocked_w[i]) begin
          per_prdata = per_prdata | unit_prdata[i];
        end
      end
    end
  end

  // sticky fault flags, set wins over clear
  wire pcg_gate_t fault_clr_w = (wr_en_w && hit_fault_w) ? word_to_gate(req.wdata) : '0;
  wire pcg_gate_t fault_set_w = fault_pulse_w;
  assign fault_nxt = (fault_r & ~fault_clr_w) | fault_set_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= '0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // status word: effective gates and power state
  logic [31:0] eff_status_w;
  always_comb begin
    eff_status_w = gate_to_word(eff_gate);
    eff_status_w[`PCG_PSTATE_LSB +: 2] = pstate_r;
  end

  // read mux
  always_comb begin
    prdata_nxt = 32'h00000000;
    if (hit_run_w) begin
      prdata_nxt = run_state_periph_clock_gate_r;
    end else if (hit_sleep_w) begin
      prdata_nxt = sleep_state_periph_clock_gate_r;
    end else if (hit_deep_w) begin
      prdata_nxt = deep_sleep_periph_clock_gate_r;
    end else if (hit_ctrl_w) begin
      prdata_nxt[`PCG_ACG_BIT] = auto_clock_gating_select_r;
    end else if (hit_eff_w) begin
      prdata_nxt = eff_status_w;
    end else if (hit_fault_w) begin
      prdata_nxt = gate_to_word(fault_r);
    end
  end

  // read data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup_w && !req.write) begin
      prdata_r <= prdata_nxt;
    end
  end

  // zero wait apb answer
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = access_w & ~hit_any_w;

endmodule : pcg_clock_gate_ctrl

// [verif/pcg_clock_gate_ctrl_monitor.sv]
/*
  checker for the clock gating block: register answers, gate selection, unit guard.
  assumes it is bound to pcg_clock_gate_ctrl and sees its ports only.
*/
module pcg_clock_gate_ctrl_monitor
  import pcg_pkg::*;
#(
  parameter int NUM_UNITS = 7,
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  input wire logic [NUM_UNITS-1:0] unit_clk_en,
  input wire logic [NUM_UNITS-1:0] per_psel,
  input wire logic per_penable,
  input wire logic [31:0] per_prdata,
  input wire logic per_pready,
  input wire logic per_pslverr,
  input wire logic [NUM_UNITS-1:0] unit_psel,
  input wire logic [NUM_UNITS-1:0] unit_pready,
  input wire logic [NUM_UNITS-1:0] unit_pslverr
);
  logic auto_r;
  logic [31:0] run_r, slp_r, deep_r;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic hit = paddr inside {12'h000, 12'h004, 12'h008, 12'h104, 12'h114, 12'h124};
  wire logic ps = |per_psel && !per_penable;
  wire logic [NUM_UNITS-1:0] blk = per_psel & ~unit_clk_en;
  wire logic [31:0] wm = pwdata & 32'h000f0111;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_r <= 1'b0;
      run_r <= 32'h0;
      slp_r <= 32'h0;
      deep_r <= 32'h0;
    end else if (wr_acc) begin
      if (paddr == 12'h000) auto_r <= pwdata[0];
      if (paddr == 12'h104) run_r <= wm;
      if (paddr == 12'h114) slp_r <= wm;
      if (paddr == 12'h124) deep_r <= wm;
    end
  end

  function automatic logic [6:0] units_of(input logic [31:0] g);
    return {g[19:16], g[8], g[4], g[0]};
  endfunction : units_of

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_addr_decode: assert property (psel && penable |-> pslverr == !hit)
    else $error("bus error flag wrong for address");
  a_run_readback: assert property (rd_acc && paddr == 12'h104 |-> prdata == run_r)
    else $error("run gate read value wrong");
  a_sleep_readback: assert property (rd_acc && paddr == 12'h114 |-> prdata == slp_r)
    else $error("sleep gate read value wrong");
  a_run_gates: assert property (((!auto_r || (!sleep_mode && !deep_sleep_mode)) && !wr_acc) [*3]
    |-> unit_clk_en == units_of(run_r)) else $error("run gates not applied");
  a_sleep_gates: assert property ((auto_r && sleep_mode && !deep_sleep_mode && !wr_acc) [*3]
    |-> unit_clk_en == units_of(slp_r)) else $error("sleep gates not applied");
  a_deep_gates: assert property ((auto_r && deep_sleep_mode && !wr_acc) [*3]
    |-> unit_clk_en == units_of(deep_r)) else $error("deep gates not applied");
  a_blocked_hidden: assert property (ps && |blk |-> unit_psel == '0 && per_pready)
    else $error("gated unit selected");
  a_blocked_fault: assert property ((ps && |blk) ##1 per_penable |-> per_pslverr && per_prdata == 32'h0)
    else $error("gated unit access not faulted");
  a_open_pass: assert property ((ps && blk == '0) ##1 (per_penable && $stable(per_psel))
    |-> unit_psel == per_psel && per_pslverr == |(unit_pslverr & per_psel)) else $error("unit answer lost");
  a_reset_clear: assert property ($rose(presetn) |-> unit_clk_en == '0 && prdata == 32'h0)
    else $error("state not clear after reset");

  cover property (wr_acc && paddr == 12'h104);
  cover property (ps && |blk);
  cover property (auto_r && deep_sleep_mode);
endmodule : pcg_clock_gate_ctrl_monitor

bind pcg_clock_gate_ctrl pcg_clock_gate_ctrl_monitor #(.NUM_UNITS(NUM_UNITS), .ADDR_W(ADDR_W)) u_mon (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .sleep_mode(sleep_mode),
  .deep_sleep_mode(deep_sleep_mode), .unit_clk_en(unit_clk_en), .per_psel(per_psel),
  .per_penable(per_penable), .per_prdata(per_prdata), .per_pready(per_pready),
  .per_pslverr(per_pslverr), .unit_psel(unit_psel), .unit_pready(unit_pready), .unit_pslverr(unit_pslverr));

// [verif/pcg_clock_gate_ctrl_tb.sv]
/*
  self-checking bench for the clock gating block over apb and the unit bus.
  assumes zero-wait apb and a two-edge lag from gate change to unit clock enable.
*/
module pcg_clock_gate_ctrl_tb
  import pcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, per_prdata;
  logic pready, pslverr, per_pready, per_pslverr, per_penable = 1'b0;
  logic sleep_mode = 1'b0, deep_sleep_mode = 1'b0;
  logic [6:0] unit_clk_en, unit_psel, per_psel = 7'h00, unit_pready = 7'h7f, unit_pslverr = 7'h02;
  logic [6:0][31:0] unit_prdata;
  int num_errors = 0, n_compared = 0;
  int pos[7] = '{0, 4, 8, 16, 17, 18, 19};
  logic [31:0] rmw_d;
  logic rmw_e;

  always #20 pclk = ~pclk;

  pcg_clock_gate_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
    .unit_clk_en(unit_clk_en), .per_psel(per_psel), .per_penable(per_penable),
    .per_prdata(per_prdata), .per_pready(per_pready), .per_pslverr(per_pslverr),
    .unit_psel(unit_psel), .unit_pready(unit_pready), .unit_pslverr(unit_pslverr),
    .unit_prdata(unit_prdata));

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one transfer on either bus; sel picks apb (0) or the unit bus (1)
  task automatic xfer(input logic sel, input int u, input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    if (sel) begin
      per_psel <= 7'h01 << u;
    end else begin
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
    end
    @(posedge pclk);
    penable <= !sel;
    per_penable <= sel;
    k = 0;
    @(posedge pclk);
    while ((sel ? per_pready : pready) !== 1'b1 && k < 16) begin
      @(posedge pclk);
      k++;
    end
    if (k == 16) begin
      num_errors++;
      wrap_up();
    end
    r = sel ? per_prdata : prdata;
    e = sel ? per_pslverr : pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    per_psel <= 7'h00;
    per_penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b0, 0, a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic sel, input int u, input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    xfer(sel, u, a, 1'b0, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  task automatic gates(input logic [6:0] x);
    repeat (3) @(posedge pclk);
    chk({25'h0, unit_clk_en}, {25'h0, x});
  endtask : gates

  initial begin
    for (int i = 0; i < 7; i++) begin
      unit_prdata[i] <= 32'hc0de0000 + i;
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    gates(7'h00);
    rd(1'b0, 0, 12'h104, 32'h0, 1'b0);
    rd(1'b0, 0, 12'h114, 32'h0, 1'b0);
    $display("reset test done");
    wr(12'h104, 32'hffffffff);
    rd(1'b0, 0, 12'h104, 32'h000f0111, 1'b0);
    gates(7'h7f);
    for (int i = 0; i < 7; i++) begin
      wr(12'h104, 32'h1 << pos[i]);
      gates(7'h01 << i);
    end
    wr(12'h114, 32'h00050110);
    rd(1'b0, 0, 12'h114, 32'h00050110, 1'b0);
    rd(1'b0, 0, 12'h104, 32'h00080000, 1'b0);
    rd(1'b0, 0, 12'h100, 32'h0, 1'b1);
    $display("register test done");
    wr(12'h104, 32'h0);
    rd(1'b1, 2, 12'h0, 32'h0, 1'b1);
    wr(12'h104, 32'h00000113);
    gates(7'h07);
    rd(1'b1, 2, 12'h0, 32'hc0de0002, 1'b0);
    rd(1'b1, 1, 12'h0, 32'hc0de0001, 1'b1);
    rd(1'b1, 6, 12'h0, 32'h0, 1'b1);
    rd(1'b0, 0, 12'h008, 32'h00080100, 1'b0);
    wr(12'h008, 32'h00080100);
    rd(1'b0, 0, 12'h008, 32'h0, 1'b0);
    xfer(1'b0, 0, 12'h104, 1'b0, 32'h0, rmw_d, rmw_e);
    chk(rmw_d, 32'h00000111);
    wr(12'h104, rmw_d | 32'h00080000);
    rd(1'b0, 0, 12'h104, 32'h00080111, 1'b0);
    gates(7'h47);
    $display("unit guard test done");
    wr(12'h104, 32'hffffffff);
    sleep_mode <= 1'b1;
    gates(7'h7f);
    deep_sleep_mode <= 1'b1;
    gates(7'h7f);
    deep_sleep_mode <= 1'b0;
    wr(12'h000, 32'h1);
    gates(7'h2e);
    rd(1'b0, 0, 12'h004, 32'h01050110, 1'b0);
    deep_sleep_mode <= 1'b1;
    gates(7'h00);
    wr(12'h124, 32'h1);
    gates(7'h01);
    rd(1'b0, 0, 12'h004, 32'h02000001, 1'b0);
    sleep_mode <= 1'b0;
    deep_sleep_mode <= 1'b0;
    gates(7'h7f);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    gates(7'h00);
    rd(1'b0, 0, 12'h104, 32'h0, 1'b0);
    $display("power state test done");
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
endmodule : pcg_clock_gate_ctrl_tb
